// [rtl/ldg_pkg.sv]
// constants and helpers for logical device irq/dma gating and floppy config
`default_nettype none
package ldg_pkg;
    // ------------------------------------------------------------
    // logical device numbers and register indexes
    // ------------------------------------------------------------
    localparam logic [7:0] LDN_FLOPPY = 8'h00;
    localparam logic [7:0] LDN_PARALLEL = 8'h03;
    localparam logic [7:0] LDN_SERIAL1 = 8'h04;
    localparam logic [7:0] LDN_SERIAL2 = 8'h05;
    localparam logic [7:0] IDX_IRQ_SELECT = 8'h70;
    localparam logic [7:0] IDX_DMA_SELECT = 8'h74;
    localparam logic [7:0] IDX_FLOPPY_MODE = 8'hF0;
    localparam logic [7:0] IDX_FLOPPY_OPTION = 8'hF1;
    localparam logic [7:0] IDX_DRIVE_TYPE = 8'hF2;
    localparam logic [7:0] IDX_FLOPPY_ZERO = 8'hF3;
    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [3:0] IRQ_SEL_NONE = 4'h0;
    localparam logic [3:0] IRQ_SEL_FLOPPY_RST = 4'h6;
    localparam logic [3:0] IRQ_SEL_SHARED_SMI = 4'h2;
    localparam logic [2:0] DMA_SEL_RESERVED = 3'h0;
    localparam logic [2:0] DMA_SEL_FLOPPY_RST = 3'h2;
    localparam logic [2:0] DMA_SEL_NONE_RST = 3'h4;
    localparam logic [2:0] DMA_SEL_LAST = 3'h3;
    localparam logic [7:0] FLOPPY_MODE_RST = 8'h0E;
    localparam logic [7:0] FLOPPY_OPTION_RST = 8'h00;
    localparam logic [7:0] DRIVE_TYPE_RST = 8'hFF;
    localparam logic [7:0] FLOPPY_MODE_WMASK = 8'hCF;
    localparam logic [7:0] FLOPPY_OPTION_WMASK = 8'h0D;
    localparam logic [7:0] DRIVE_TYPE_WMASK = 8'hFF;
    // ------------------------------------------------------------
    // field positions and encodings
    // ------------------------------------------------------------
    localparam int FM_ENHANCED_BIT = 0;
    localparam int FM_NON_BURST_BIT = 1;
    localparam int FM_IFACE_LSB = 2;
    localparam int FM_PUSH_PULL_BIT = 6;
    localparam int FM_TRISTATE_BIT = 7;
    localparam int FO_FORCE_WP_BIT = 0;
    localparam int FO_DENSITY_LSB = 2;
    localparam int DT_A_LSB = 0;
    localparam int DT_B_LSB = 2;
    localparam logic [1:0] DENS_FORCE_HIGH = 2'h2;
    localparam logic [1:0] DENS_FORCE_LOW = 2'h3;
    localparam logic [2:0] ECR_MODE_FIFO = 3'h2;
    localparam logic [2:0] ECR_MODE_ECP = 3'h3;
    localparam logic [2:0] ECR_MODE_TEST = 3'h6;
    localparam int NUM_IRQ_SRC = 4;
    localparam int NUM_DMA_SRC = 3;

    typedef logic [3:0] ldg_irq_sel_t;
    typedef logic [2:0] ldg_dma_sel_t;

    function automatic logic ldg_dma_valid(input ldg_dma_sel_t sel);
        ldg_dma_valid = (sel != DMA_SEL_RESERVED) && (sel <= DMA_SEL_LAST);
    endfunction

    function automatic logic ldg_ecr_irq_on(input logic [2:0] mode);
        ldg_ecr_irq_on = (mode == ECR_MODE_FIFO) || (mode == ECR_MODE_ECP)
            || (mode == ECR_MODE_TEST);
    endfunction
endpackage
`default_nettype wire

// [rtl/ldg_line_router.sv]
// routes gated device requests onto the selected irq and dma lines
`default_nettype none
module ldg_line_router
    import ldg_pkg::*;
(
    input wire logic [NUM_IRQ_SRC-1:0][3:0] irq_sel,
    input wire logic [NUM_IRQ_SRC-1:0] irq_req,
    input wire logic [NUM_DMA_SRC-1:0][2:0] dma_sel,
    input wire logic [NUM_DMA_SRC-1:0] dma_req,
    output logic [15:0] irq_lines,
    output logic [15:0] irq_used,
    output logic [3:0] dma_lines
);
    always_comb
    begin
        irq_lines = 16'h0000;
        irq_used = 16'h0000;
        dma_lines = 4'h0;
        for (int i = 0; i < NUM_IRQ_SRC; i++)
        begin
            // selector zero drives nothing; unused lines stay low
            if (irq_sel[i] != IRQ_SEL_NONE)
            begin
                irq_used[irq_sel[i]] = 1'b1;
                irq_lines[irq_sel[i]] = irq_lines[irq_sel[i]] | irq_req[i];
            end
        end
        for (int j = 0; j < NUM_DMA_SRC; j++)
        begin
            if (ldg_dma_valid(dma_sel[j]))
            begin
                dma_lines[dma_sel[j][1:0]] = dma_lines[dma_sel[j][1:0]] | dma_req[j];
            end
        end
    end
endmodule // ldg_line_router
`default_nettype wire

// [rtl/ldg_gating_top.sv]
// logical device irq/dma gating and floppy vendor configuration registers
// Function
// - irq needs non-zero select and, for floppy, the drive control gate bit
// - parallel irq needs printer irq enable except in ecp modes 010, 011, 110; ecp also needs service mask clear
// - serial irq needs some of enable bits 0..3 and the aux modem output
// - an irq line nobody selects and enables stays low
// - every irq number 1..15 is selectable and delivered as a line
// - floppy irq select resets to 6, other devices to none
// - dma select bits 2:0: 0 reserved, 1..3 channels, 4..7 none
// - dma select resets to 2 for floppy, 4 for devices 3 and 5
// - dma active only for select 1..3 with the owner's enable
// - floppy gate low or powered down kills irq, dma and acks
// - serial irq off while aux modem output bit is zero
// - standard and epp parallel irq off while printer irq enable is zero
// - ecp modes 010, 011, 110 irq on while service mask clear; dma always by ecp gate
// - vendor registers reset only on hard reset, not soft reset
// - interface mode 11 standard, 10 reserved, 01/00 legacy variants
// - mode bit6 push-pull, bit7 tristates floppy outputs
// - forced write protect active on any selected drive, ORed with others
// - density 00/01 normal, 10 forces one, 11 forces zero
// - drive type resets 0xFF: a in 1:0, b in 3:2, 7:4 storage
// - index 0xF3 is read only and reads zero
// - irq select bits 3:0 choose line, 0 none, 2 shared; here select 2 only drives irq line 2, there is no smi
`default_nettype none
module ldg_gating_top
    import ldg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic [7:0] cfg_ldn,
    input wire logic [7:0] cfg_index,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_rd,
    input wire logic floppy_dma_irq_gate,
    input wire logic floppy_power_down,
    input wire logic floppy_irq_req,
    input wire logic floppy_dma_req,
    input wire logic printer_irq_enable,
    input wire logic ecp_mode,
    input wire logic [2:0] ecr_mode,
    input wire logic ecp_service_int_mask,
    input wire logic ecp_dma_gate,
    input wire logic printer_irq_req,
    input wire logic printer_dma_request,
    input wire logic [3:0] uart1_int_enable_reg,
    input wire logic uart1_modem_aux_output_b,
    input wire logic uart1_irq_req,
    input wire logic [3:0] uart2_int_enable_reg,
    input wire logic uart2_modem_aux_output_b,
    input wire logic uart2_irq_req,
    input wire logic [3:0] dma_ack,
    input wire logic write_protect_input_n,
    input wire logic drive_select_first_n,
    input wire logic drive_select_second_n,
    input wire logic floppy_global_wp,
    input wire logic density_in,
    output logic [7:0] cfg_rdata,
    output logic [15:0] irq_line,
    output logic [3:0] dma_request,
    output logic floppy_dack,
    output logic printer_dack,
    output logic write_protect_core_n,
    output logic floppy_status_a_wp,
    output logic density_out,
    output logic floppy_enhanced_mode,
    output logic floppy_dma_non_burst,
    output logic [1:0] floppy_interface_mode,
    output logic floppy_out_push_pull,
    output logic floppy_out_tristate,
    output logic [1:0] drive_a_type,
    output logic [1:0] drive_b_type
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_q <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_q <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // source order: 0 floppy, 1 parallel, 2 serial1, 3 serial2
    ldg_irq_sel_t [NUM_IRQ_SRC-1:0] irq_sel;
    ldg_irq_sel_t [NUM_IRQ_SRC-1:0] next_irq_sel;
    // source order: 0 floppy, 1 parallel, 2 serial2 (stored only)
    ldg_dma_sel_t [NUM_DMA_SRC-1:0] dma_sel;
    ldg_dma_sel_t [NUM_DMA_SRC-1:0] next_dma_sel;
    logic [7:0] floppy_mode_config;
    logic [7:0] next_floppy_mode_config;
    logic [7:0] floppy_option_config;
    logic [7:0] next_floppy_option_config;
    logic [7:0] floppy_drive_type;
    logic [7:0] next_floppy_drive_type;
    logic [7:0] next_cfg_rdata;
    int irq_src;
    int dma_src;

    always_comb
    begin
        unique case (cfg_ldn)
            LDN_FLOPPY: irq_src = 0;
            LDN_PARALLEL: irq_src = 1;
            LDN_SERIAL1: irq_src = 2;
            LDN_SERIAL2: irq_src = 3;
            default: irq_src = -1;
        endcase
        unique case (cfg_ldn)
            LDN_FLOPPY: dma_src = 0;
            LDN_PARALLEL: dma_src = 1;
            LDN_SERIAL2: dma_src = 2;
            default: dma_src = -1;
        endcase
    end

    always_comb
    begin
        next_irq_sel = irq_sel;
        next_dma_sel = dma_sel;
        next_floppy_mode_config = floppy_mode_config;
        next_floppy_option_config = floppy_option_config;
        next_floppy_drive_type = floppy_drive_type;
        next_cfg_rdata = cfg_rdata;
        if (cfg_wr)
        begin
            if (cfg_index == IDX_IRQ_SELECT && irq_src >= 0)
            begin
                next_irq_sel[irq_src] = cfg_wdata[3:0];
            end
            if (cfg_index == IDX_DMA_SELECT && dma_src >= 0)
            begin
                next_dma_sel[dma_src] = cfg_wdata[2:0];
            end
            if (cfg_ldn == LDN_FLOPPY)
            begin
                unique case (cfg_index)
                    IDX_FLOPPY_MODE:
                        next_floppy_mode_config = cfg_wdata & FLOPPY_MODE_WMASK;
                    IDX_FLOPPY_OPTION:
                        next_floppy_option_config = cfg_wdata & FLOPPY_OPTION_WMASK;
                    IDX_DRIVE_TYPE: next_floppy_drive_type = cfg_wdata & DRIVE_TYPE_WMASK;
                    default: next_floppy_drive_type = floppy_drive_type;
                endcase
            end
        end
        // soft reset restores only the standard selects, never vendor registers
        if (soft_reset)
        begin
            next_irq_sel = {IRQ_SEL_NONE, IRQ_SEL_NONE, IRQ_SEL_NONE, IRQ_SEL_FLOPPY_RST};
            next_dma_sel = {DMA_SEL_NONE_RST, DMA_SEL_NONE_RST, DMA_SEL_FLOPPY_RST};
        end
        if (cfg_rd)
        begin
            next_cfg_rdata = 8'h00;
            if (cfg_index == IDX_IRQ_SELECT && irq_src >= 0)
            begin
                next_cfg_rdata = {4'h0, irq_sel[irq_src]};
            end
            if (cfg_index == IDX_DMA_SELECT && dma_src >= 0)
            begin
                next_cfg_rdata = {5'h00, dma_sel[dma_src]};
            end
            if (cfg_ldn == LDN_FLOPPY)
            begin
                unique case (cfg_index)
                    IDX_FLOPPY_MODE: next_cfg_rdata = floppy_mode_config;
                    IDX_FLOPPY_OPTION: next_cfg_rdata = floppy_option_config;
                    IDX_DRIVE_TYPE: next_cfg_rdata = floppy_drive_type;
                    IDX_FLOPPY_ZERO: next_cfg_rdata = 8'h00;
                    default: next_cfg_rdata = next_cfg_rdata;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_q)
    begin
        if (!rst_q)
        begin
            irq_sel <= {IRQ_SEL_NONE, IRQ_SEL_NONE, IRQ_SEL_NONE, IRQ_SEL_FLOPPY_RST};
            dma_sel <= {DMA_SEL_NONE_RST, DMA_SEL_NONE_RST, DMA_SEL_FLOPPY_RST};
            floppy_mode_config <= FLOPPY_MODE_RST;
            floppy_option_config <= FLOPPY_OPTION_RST;
            floppy_drive_type <= DRIVE_TYPE_RST;
            cfg_rdata <= 8'h00;
        end
        else
        begin
            irq_sel <= next_irq_sel;
            dma_sel <= next_dma_sel;
            floppy_mode_config <= next_floppy_mode_config;
            floppy_option_config <= next_floppy_option_config;
            floppy_drive_type <= next_floppy_drive_type;
            cfg_rdata <= next_cfg_rdata;
        end
    end

    // ------------------------------------------------------------
    // per device gating
    // ------------------------------------------------------------
    logic fdc_en;
    logic pp_irq_gate;
    logic pp_dma_gate;
    logic [1:0] uart_irq_gate;
    logic [NUM_IRQ_SRC-1:0] irq_req_gated;
    logic [NUM_DMA_SRC-1:0] dma_req_gated;
    logic [15:0] route_irq;
    logic [15:0] route_used;
    logic [3:0] route_dma;

    always_comb
    begin
        fdc_en = floppy_dma_irq_gate && !floppy_power_down;
        // ecp service mask is honoured even in the always-on modes
        if (ecp_mode)
        begin
            pp_irq_gate = (ldg_ecr_irq_on(ecr_mode) || printer_irq_enable)
                && !ecp_service_int_mask;
        end
        else
        begin
            pp_irq_gate = printer_irq_enable;
        end
        pp_dma_gate = ecp_mode && ecp_dma_gate;
        uart_irq_gate[0] = (|uart1_int_enable_reg) && uart1_modem_aux_output_b;
        uart_irq_gate[1] = (|uart2_int_enable_reg) && uart2_modem_aux_output_b;
        irq_req_gated = {uart2_irq_req && uart_irq_gate[1], uart1_irq_req && uart_irq_gate[0],
            printer_irq_req && pp_irq_gate, floppy_irq_req && fdc_en};
        // serial port 2 owns no dma request line here
        dma_req_gated = {1'b0, printer_dma_request && pp_dma_gate, floppy_dma_req && fdc_en};
    end

    ldg_line_router u_router (
        .irq_sel(irq_sel),
        .irq_req(irq_req_gated),
        .dma_sel(dma_sel),
        .dma_req(dma_req_gated),
        .irq_lines(route_irq),
        .irq_used(route_used),
        .dma_lines(route_dma)
    );

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic [15:0] next_irq_line;
    logic [3:0] next_dma_request;
    logic next_floppy_dack;
    logic next_printer_dack;
    logic wp_active;
    logic next_density_out;

    always_comb
    begin
        next_irq_line = route_irq & route_used;
        next_dma_request = route_dma;
        next_floppy_dack = fdc_en && ldg_dma_valid(dma_sel[0])
            && dma_ack[dma_sel[0][1:0]];
        next_printer_dack = pp_dma_gate && ldg_dma_valid(dma_sel[1])
            && dma_ack[dma_sel[1][1:0]];
        wp_active = (floppy_option_config[FO_FORCE_WP_BIT]
            && (!drive_select_first_n || !drive_select_second_n))
            || !write_protect_input_n || floppy_global_wp;
        unique case (floppy_option_config[FO_DENSITY_LSB +: 2])
            DENS_FORCE_HIGH: next_density_out = 1'b1;
            DENS_FORCE_LOW: next_density_out = 1'b0;
            default: next_density_out = density_in;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_q)
    begin
        if (!rst_q)
        begin
            irq_line <= 16'h0000;
            dma_request <= 4'h0;
            floppy_dack <= 1'b0;
            printer_dack <= 1'b0;
            write_protect_core_n <= 1'b1;
            floppy_status_a_wp <= 1'b0;
            density_out <= 1'b0;
            floppy_enhanced_mode <= 1'b0;
            floppy_dma_non_burst <= 1'b0;
            floppy_interface_mode <= 2'h0;
            floppy_out_push_pull <= 1'b0;
            floppy_out_tristate <= 1'b0;
            drive_a_type <= 2'h0;
            drive_b_type <= 2'h0;
        end
        else
        begin
            irq_line <= next_irq_line;
            dma_request <= next_dma_request;
            floppy_dack <= next_floppy_dack;
            printer_dack <= next_printer_dack;
            write_protect_core_n <= !wp_active;
            floppy_status_a_wp <= wp_active;
            density_out <= next_density_out;
            floppy_enhanced_mode <= floppy_mode_config[FM_ENHANCED_BIT];
            floppy_dma_non_burst <= floppy_mode_config[FM_NON_BURST_BIT];
            floppy_interface_mode <= floppy_mode_config[FM_IFACE_LSB +: 2];
            floppy_out_push_pull <= floppy_mode_config[FM_PUSH_PULL_BIT];
            floppy_out_tristate <= floppy_mode_config[FM_TRISTATE_BIT];
            drive_a_type <= floppy_drive_type[DT_A_LSB +: 2];
            drive_b_type <= floppy_drive_type[DT_B_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_q);

    sequence s_fdc_irq_write;
        cfg_wr && !cfg_rd && !soft_reset && cfg_ldn == LDN_FLOPPY && cfg_index == IDX_IRQ_SELECT;
    endsequence
    sequence s_fdc_irq_read;
        !cfg_wr && cfg_rd && !soft_reset && cfg_ldn == LDN_FLOPPY && cfg_index == IDX_IRQ_SELECT;
    endsequence

    AST_IRQ_SEL_READBACK: assert property (s_fdc_irq_write ##1 s_fdc_irq_read
        |=> cfg_rdata == ($past(cfg_wdata, 2) & 8'h0F))
        else $error("irq select readback mismatch");
    AST_F3_ZERO: assert property (cfg_rd && cfg_ldn == LDN_FLOPPY
        && cfg_index == IDX_FLOPPY_ZERO |=> cfg_rdata == 8'h00)
        else $error("index f3 read not zero");
    AST_FDC_GATE: assert property ((!floppy_dma_irq_gate || floppy_power_down)
        |=> !floppy_dack && !(irq_line[$past(irq_sel[0])] && $past(irq_sel[3:1]) == '0))
        else $error("floppy irq or dack while gated");
    AST_IRQ_UNUSED_LOW: assert property ((irq_line & ~$past(route_used)) == 16'h0000)
        else $error("unused irq line active");
    AST_DMA_NONE: assert property (dma_request[0] == 1'b0
        && !(floppy_dack && !ldg_dma_valid($past(dma_sel[0]))))
        else $error("dma active on reserved or none select");
    AST_UART_AUX: assert property (!uart1_modem_aux_output_b && irq_sel[0] == 4'h0
        && irq_sel[1] == 4'h0 && irq_sel[3] == 4'h0 |=> irq_line == 16'h0000)
        else $error("serial irq with aux output low");
    AST_SOFT_KEEPS_VENDOR: assert property (soft_reset && !cfg_wr
        |=> floppy_mode_config == $past(floppy_mode_config) && irq_sel[0] == 4'h6)
        else $error("soft reset touched vendor register");
    AST_DENSITY_FORCE: assert property (floppy_option_config[3:2] == 2'h2
        ##1 floppy_option_config[3:2] == 2'h2 |-> density_out)
        else $error("density not forced high");
    AST_FORCED_WP: assert property (floppy_option_config[0] && !drive_select_first_n
        |=> !write_protect_core_n && floppy_status_a_wp)
        else $error("forced write protect not applied");
    AST_ECP_ON_MODE: assert property (ecp_mode && ecr_mode == 3'h3 && !ecp_service_int_mask
        && printer_irq_req && irq_sel[1] == 4'h5 |=> irq_line[5])
        else $error("ecp irq not forced on");
endmodule // ldg_gating_top
`default_nettype wire

// [sim/ldg_host_model.sv]
// host side driver of the configuration index/data port
`default_nettype none
module ldg_host_model (
    input wire logic clk_sys,
    output logic [7:0] cfg_ldn,
    output logic [7:0] cfg_index,
    output logic cfg_wr,
    output logic [7:0] cfg_wdata,
    output logic cfg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------------------
    // one byte access, held for one full cycle
    // -------------------------------------------------------------
    // no management interrupt exists here, so line 2 is free to use
    initial
    begin
        {cfg_ldn, cfg_index, cfg_wr, cfg_wdata, cfg_rd} = '0;
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] i,
        input logic [7:0] d);
        @(negedge clk_sys);
        cfg_ldn = a;
        cfg_index = i;
        cfg_wdata = d;
        cfg_wr = w;
        cfg_rd = !w;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        // released data shows the inverse, never a stale match
        cfg_wdata = ~d;
    endtask
    // write, then read back in the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] i, input logic [7:0] d);
        @(negedge clk_sys);
        {cfg_ldn, cfg_index, cfg_wdata, cfg_wr, cfg_rd} = {a, i, d, 2'b10};
        @(negedge clk_sys);
        {cfg_wr, cfg_rd} = 2'b01;
        @(negedge clk_sys);
        {cfg_wr, cfg_rd, cfg_wdata} = {2'b00, ~d};
    endtask
endmodule // ldg_host_model
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for irq/dma gating and floppy configuration
`default_nettype none
`define CHK(n, e, a) chk(n, 16'(e), 16'(a))
module tb
    import ldg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic soft_reset = 1'b0;
    wire logic [7:0] cfg_ldn, cfg_index, cfg_wdata;
    wire logic cfg_wr, cfg_rd;
    logic floppy_dma_irq_gate, floppy_power_down, floppy_irq_req, floppy_dma_req;
    logic printer_irq_enable, ecp_mode, ecp_service_int_mask, ecp_dma_gate;
    logic printer_irq_req, printer_dma_request, uart1_modem_aux_output_b, uart1_irq_req;
    logic uart2_modem_aux_output_b, uart2_irq_req, write_protect_input_n;
    logic drive_select_first_n, drive_select_second_n, floppy_global_wp, density_in;
    logic [2:0] ecr_mode;
    logic [3:0] uart1_int_enable_reg, uart2_int_enable_reg, dma_ack, dma_request;
    logic [7:0] cfg_rdata, fm, fo, ft, l, idx;
    logic [15:0] irq_line;
    logic floppy_dack, printer_dack, write_protect_core_n, floppy_status_a_wp, density_out;
    logic floppy_enhanced_mode, floppy_dma_non_burst, floppy_out_push_pull, floppy_out_tristate;
    logic [1:0] floppy_interface_mode, drive_a_type, drive_b_type;
    logic [3:0] isel [6];
    logic [2:0] dsel [6];
    logic [63:0] r;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] lt [5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05};
    logic [7:0] it [6] = '{8'h70, 8'h74, 8'hF0, 8'hF1, 8'hF2, 8'hF3};

    ldg_gating_top dut (.*);
    ldg_host_model host (.*);

    always #5 clk_sys = ~clk_sys;
    // -------------------------------------------------------------
    // reference model
    // -------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] a);
        n_compared++;
        if (a !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, a);
        end
    endtask
    task automatic set_inputs(input logic [63:0] v);
        {floppy_dma_irq_gate, floppy_power_down, floppy_irq_req, floppy_dma_req,
            printer_irq_enable, ecp_mode, ecr_mode, ecp_service_int_mask, ecp_dma_gate,
            printer_irq_req, printer_dma_request, uart1_int_enable_reg,
            uart1_modem_aux_output_b, uart1_irq_req, uart2_int_enable_reg,
            uart2_modem_aux_output_b, uart2_irq_req, dma_ack, write_protect_input_n,
            drive_select_first_n, drive_select_second_n, floppy_global_wp, density_in} = v[33:0];
    endtask
    task automatic srst();
        isel = '{4'h6, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
        dsel = '{3'h2, 3'h0, 3'h0, 3'h4, 3'h0, 3'h4};
    endtask
    function automatic logic [7:0] rdm(input logic [7:0] a, input logic [7:0] i);
        case (i)
            8'h70: rdm = (a inside {0, 3, 4, 5}) ? {4'h0, isel[a]} : 8'h00;
            8'h74: rdm = (a inside {0, 3, 5}) ? {5'h00, dsel[a]} : 8'h00;
            8'hF0: rdm = (a == 8'h00) ? fm : 8'h00;
            8'hF1: rdm = (a == 8'h00) ? fo : 8'h00;
            8'hF2: rdm = (a == 8'h00) ? ft : 8'h00;
            default: rdm = 8'h00;
        endcase
    endfunction
    task automatic mw(input logic [7:0] a, input logic [7:0] i, input logic [7:0] d);
        if (i == 8'h70 && a inside {0, 3, 4, 5}) isel[a] = d[3:0];
        if (i == 8'h74 && a inside {0, 3, 5}) dsel[a] = d[2:0];
        if (a == 8'h00 && i == 8'hF0) fm = d & 8'hCF;
        if (a == 8'h00 && i == 8'hF1) fo = d & 8'h0D;
        if (a == 8'h00 && i == 8'hF2) ft = d;
    endtask
    task automatic check_outputs();
        logic [15:0] ei;
        logic [3:0] ed;
        logic fen, pi, wp, dn, fd, pd;
        fen = floppy_dma_irq_gate & ~floppy_power_down;
        pi = ecp_mode ? ((ecr_mode inside {3'h2, 3'h3, 3'h6}) | printer_irq_enable)
            & ~ecp_service_int_mask : printer_irq_enable;
        ei = 16'h0000;
        ei[isel[0]] |= floppy_irq_req & fen;
        ei[isel[3]] |= printer_irq_req & pi;
        ei[isel[4]] |= uart1_irq_req & |uart1_int_enable_reg & uart1_modem_aux_output_b;
        ei[isel[5]] |= uart2_irq_req & |uart2_int_enable_reg & uart2_modem_aux_output_b;
        ei[0] = 1'b0;
        ed = 4'h0;
        ed[dsel[0]] |= floppy_dma_req & fen & (dsel[0] inside {3'h1, 3'h2, 3'h3});
        ed[dsel[3]] |= printer_dma_request & ecp_mode & ecp_dma_gate
            & (dsel[3] inside {3'h1, 3'h2, 3'h3});
        wp = (fo[0] & (~drive_select_first_n | ~drive_select_second_n))
            | ~write_protect_input_n | floppy_global_wp;
        dn = fo[3:2] == 2'h2 ? 1'b1 : fo[3:2] == 2'h3 ? 1'b0 : density_in;
        fd = fen & (dsel[0] inside {3'h1, 3'h2, 3'h3}) & dma_ack[dsel[0][1:0]];
        pd = ecp_mode & ecp_dma_gate & (dsel[3] inside {3'h1, 3'h2, 3'h3})
            & dma_ack[dsel[3][1:0]];
        `CHK("irq_line", ei, irq_line);
        `CHK("dma_request", ed, dma_request);
        `CHK("write_protect", {~wp, wp}, {write_protect_core_n, floppy_status_a_wp});
        `CHK("density", dn, density_out);
        `CHK("mode_fields", {fm[7:6], fm[3:0], ft[3:0]}, {floppy_out_tristate,
            floppy_out_push_pull, floppy_interface_mode, floppy_dma_non_burst,
            floppy_enhanced_mode, drive_b_type, drive_a_type});
        `CHK("dack", {fd, pd}, {floppy_dack, printer_dack});
    endtask
    task automatic finish_test();
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // -------------------------------------------------------------
    // sequence
    // -------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            miscompares = miscompares + 1;
            finish_test();
        end
    end
    initial
    begin
        void'($urandom(17006));
        set_inputs(64'h0);
        srst();
        fm = 8'h0E;
        fo = 8'h00;
        ft = 8'hFF;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        foreach (lt[a])
            foreach (it[b])
            begin
                host.acc(1'b0, lt[a], it[b], 8'h00);
                `CHK("reset_value", rdm(lt[a], it[b]), cfg_rdata);
            end
        host.wr_rd(8'h00, 8'h70, 8'hA5);
        mw(8'h00, 8'h70, 8'hA5);
        `CHK("irq_readback", rdm(8'h00, 8'h70), cfg_rdata);
        // gate, floppy irq and dma requests up; sweep every select
        set_inputs(64'h2C0000000);
        for (int n = 15; n >= 0; n--)
        begin
            host.acc(1'b1, 8'h00, 8'h70, 8'(n));
            mw(8'h00, 8'h70, 8'(n));
            host.acc(1'b1, 8'h00, 8'h74, 8'(n));
            mw(8'h00, 8'h74, 8'(n));
            repeat (2) @(negedge clk_sys);
            check_outputs();
        end
        repeat (400)
        begin
            r = {$urandom(), $urandom()};
            @(negedge clk_sys);
            set_inputs(r);
            l = lt[r[39:37] % 5];
            idx = it[r[42:40] % 6];
            if (r[45:43] == 3'h0)
            begin
                soft_reset = 1'b1;
                @(negedge clk_sys);
                soft_reset = 1'b0;
                srst();
            end
            else if (r[46])
            begin
                host.acc(1'b1, l, idx, r[54:47]);
                mw(l, idx, r[54:47]);
            end
            else
            begin
                host.acc(1'b0, l, idx, r[54:47]);
                `CHK("cfg_rdata", rdm(l, idx), cfg_rdata);
            end
            repeat (2) @(negedge clk_sys);
            check_outputs();
        end
        finish_test();
    end
endmodule // tb
`default_nettype wire
